// *** ucr2_control.sv ***
// upper half of the second control register with its update strobe and sync clock
`timescale 1ns/1ps

// How it works
// R1: the register is decoded at serial address 0x01 and is four bytes wide.
// R2: the primary mode field reads 00 quadrature, 01 single tone, 1x interpolating converter.
// R3: bit 31 clear keeps the eighteen data pins a parallel port, and the bit counts only in quadrature mode.
// R4: bit 31 set in quadrature mode makes pins 5 and 4 a dual serial port and the other sixteen a GPIO port.
// R5: bit 30 picks serial bit order, MSB first when clear, and is ignored with bit 31 clear.
// R6: bit 29 picks late (clear) or early (set) frame sync, and the serial source must match it.
// R7: in single tone with shift keying off, bit 24 set takes amplitude from the profile, clear bypasses at unity.
// R8: bit 23 clear makes the update pin an input and values transfer only when it is asserted.
// R9: bit 23 set makes an internal timer strobe, drives the update pin as output with that strobe.
// R10: a write to bit 23 takes effect at once without waiting for an update.
// R11: bit 22 set drives the sync clock at a quarter of the system clock, clear holds it low.
// R12: bit 16 chooses stored or live frequency tuning word on a serial read of that word.
// R13: with bit 23 set, bits 15:14 divide the update timer clock by 1, 2, 4 or 8.
// R14: bits 28 to 25 and 21 to 17 are reserved, ignored on write and read as zero.
module ucr2_control
   import ucr2_pkg::*;
#(
   parameter logic [15:0] UPDATE_TICKS = UCR2_UPDATE_TICKS,
   parameter logic [7:0] FTW_ADDR = UCR2_FTW_ADDR
) (
   input wire logic clk,
   input wire logic reset,
   input wire ucr2_bus_type bus,
   input wire logic [1:0] operating_mode,
   input wire logic osk_enable,
   input wire logic [31:0] ftw_stored,
   input wire logic [31:0] ftw_live,
   input wire logic io_update_in,
   output logic io_update_out,
   output logic io_update_oe,
   output logic update_strobe,
   output logic sync_clk,
   output ucr2_cfg_type cfg,
   output logic [31:0] read_data,
   output logic read_valid
);

   ucr2_state_type state;
   ucr2_state_type next_state;

   // last prescaler count for a rate code: divide by one, two, four or eight
   function automatic logic [2:0] prescale_last(input logic [1:0] rate);
      logic [3:0] div;
      div = 4'h1 << rate;
      return 3'(div - 4'h1);
   endfunction

   // decode the active bits against the mode of the primary register
   function automatic ucr2_cfg_type decode_cfg(input logic [31:0] act, input logic [1:0] mode,
                                               input logic output_shift_keying);
      ucr2_cfg_type c;
      logic tone_plain;
      // R2: mode codes
      tone_plain = (mode == UCR2_MODE_TONE) && !output_shift_keying;
      // R3: serial only in quadrature mode
      c.serial_port = act[UCR2_BIT_SERIAL] && (mode == UCR2_MODE_QUAD);
      c.parallel_port = !c.serial_port;
      // R4: gpio comes with serial port
      c.gpio_enable = c.serial_port;
      // R5: bit order gated
      c.lsb_first = c.serial_port && act[UCR2_BIT_LSB_FIRST];
      // R6: frame sync timing
      c.early_sync = c.serial_port && act[UCR2_BIT_EARLY_SYNC];
      // R7: amplitude source
      c.profile_asf = tone_plain && act[UCR2_BIT_PROFILE_ASF];
      c.asf_bypass = tone_plain && !act[UCR2_BIT_PROFILE_ASF];
      return c;
   endfunction

   // next state: timer, transfer, writes, reads and pin drive
   always_comb begin
      logic internal;
      logic tick;
      logic int_pulse;
      logic strobe;
      internal = 1'b0;
      tick = 1'b0;
      int_pulse = 1'b0;
      strobe = 1'b0;
      next_state = state;
      internal = state.active[UCR2_BIT_INT_UPDATE];

      // R13: prescaler feeds the update timer, idle while external
      if (internal) begin
         if (state.prescale >= prescale_last(state.active[UCR2_RATE_HI:UCR2_RATE_LO])) begin
            next_state.prescale = 3'h0;
            tick = 1'b1;
         end else begin
            next_state.prescale = state.prescale + 3'h1;
         end
      end else begin
         next_state.prescale = 3'h0;
      end

      // R9: timer produces the internal strobe
      if (!internal) begin
         next_state.timer = 16'h0000;
      end else if (tick) begin
         if (state.timer >= UPDATE_TICKS - 16'h0001) begin
            next_state.timer = 16'h0000;
            int_pulse = 1'b1;
         end else begin
            next_state.timer = state.timer + 16'h0001;
         end
      end

      // R8: external pin strobes only while bit 23 is clear
      strobe = internal ? int_pulse : io_update_in;
      if (strobe) begin
         next_state.active = state.staged;
      end

      // R1: decode of the register address
      if (bus.write && bus.addr == UCR2_CTL2_ADDR) begin
         // R14: reserved bits never stored
         next_state.staged = bus.wdata & UCR2_CTL2_WMASK;
         // R10: bit 23 bypasses the update
         next_state.active[UCR2_BIT_INT_UPDATE] = bus.wdata[UCR2_BIT_INT_UPDATE];
      end

      // serial reads answer one cycle later; unmapped addresses read zero
      next_state.read_valid = bus.read;
      next_state.read_data = state.read_data;
      if (bus.read) begin
         if (bus.addr == UCR2_CTL2_ADDR) begin
            next_state.read_data = state.staged;
         end else if (bus.addr == FTW_ADDR) begin
            // R12: stored or live tuning word
            next_state.read_data = state.active[UCR2_BIT_LIVE_FTW] ? ftw_live : ftw_stored;
         end else begin
            next_state.read_data = 32'h0000_0000;
         end
      end

      // R9: pin direction follows bit 23 as it stands after any write
      next_state.io_update_oe = next_state.active[UCR2_BIT_INT_UPDATE];
      next_state.io_update_out = int_pulse;
      next_state.update_strobe = strobe;

      // R11: quarter-rate sync clock, counter free running so the phase is fixed
      next_state.sync_count = UCR2_SYNC_BITS'(state.sync_count + 1'b1);
      next_state.sync_clk = next_state.active[UCR2_BIT_SYNC_CLK]
                            && next_state.sync_count[UCR2_SYNC_BITS-1];

      next_state.cfg = decode_cfg(next_state.active, operating_mode, osk_enable);
   end

   // state register; reset restores the documented defaults
   always_ff @(posedge clk) begin
      if (reset) begin
         state <= '0;
         state.staged <= UCR2_CTL2_RESET;
         state.active <= UCR2_CTL2_RESET;
         state.cfg.parallel_port <= 1'b1;
      end else begin
         state <= next_state;
      end
   end

   // outputs straight from the state register
   assign io_update_out = state.io_update_out;
   assign io_update_oe = state.io_update_oe;
   assign update_strobe = state.update_strobe;
   assign sync_clk = state.sync_clk;
   assign cfg = state.cfg;
   assign read_data = state.read_data;
   assign read_valid = state.read_valid;
endmodule

// *** ucr2_pkg.sv ***
// constants and carrier types for the upper half of the second control register
package ucr2_pkg;
   // register map of the serial port
   localparam logic [7:0] UCR2_CTL2_ADDR = 8'h01;
   localparam logic [7:0] UCR2_FTW_ADDR = 8'h07;
   localparam int UCR2_REG_BYTES = 4;
   // field positions
   localparam int UCR2_BIT_SERIAL = 31;
   localparam int UCR2_BIT_LSB_FIRST = 30;
   localparam int UCR2_BIT_EARLY_SYNC = 29;
   localparam int UCR2_BIT_PROFILE_ASF = 24;
   localparam int UCR2_BIT_INT_UPDATE = 23;
   localparam int UCR2_BIT_SYNC_CLK = 22;
   localparam int UCR2_BIT_LIVE_FTW = 16;
   localparam int UCR2_RATE_HI = 15;
   localparam int UCR2_RATE_LO = 14;
   // reset value and the bits that exist; reserved and lower bits read zero
   localparam logic [31:0] UCR2_CTL2_RESET = 32'h0040_0000;
   localparam logic [31:0] UCR2_CTL2_WMASK = 32'hE1C1_C000;
   // operating mode codes of the primary control register
   localparam logic [1:0] UCR2_MODE_QUAD = 2'h0;
   localparam logic [1:0] UCR2_MODE_TONE = 2'h1;
   // sync clock runs at a quarter of the system clock
   localparam int UCR2_SYNC_DIV = 4;
   localparam int UCR2_SYNC_BITS = $clog2(UCR2_SYNC_DIV);
   // default count of prescaled ticks between internal update strobes
   localparam logic [15:0] UCR2_UPDATE_TICKS = 16'h0010;

   // register access from the serial port controller
   typedef struct packed {
      logic write;
      logic read;
      logic [7:0] addr;
      logic [31:0] wdata;
   } ucr2_bus_type;

   // decoded configuration seen by the datapath
   typedef struct packed {
      logic parallel_port;
      logic serial_port;
      logic gpio_enable;
      logic lsb_first;
      logic early_sync;
      logic profile_asf;
      logic asf_bypass;
   } ucr2_cfg_type;

   // whole state of the block
   typedef struct packed {
      logic [31:0] staged;
      logic [31:0] active;
      logic [2:0] prescale;
      logic [15:0] timer;
      logic [UCR2_SYNC_BITS-1:0] sync_count;
      logic sync_clk;
      logic io_update_out;
      logic io_update_oe;
      logic update_strobe;
      ucr2_cfg_type cfg;
      logic [31:0] read_data;
      logic read_valid;
   } ucr2_state_type;
endpackage

// *** ucr2_control_sva.sv ***
// checker for the upper half of the second control register
`timescale 1ns/1ps
module ucr2_control_chk
   import ucr2_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire ucr2_bus_type bus,
   input wire logic [1:0] operating_mode,
   input wire logic io_update_in,
   input wire logic io_update_out,
   input wire logic io_update_oe,
   input wire logic update_strobe,
   input wire logic sync_clk,
   input wire ucr2_cfg_type cfg,
   input wire logic read_valid
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   // one sync period is four clocks, or the pin has gone quiet
   sequence sync_rise; $rose(sync_clk); endsequence
   sequence sync_next; ##4 ($rose(sync_clk) || !sync_clk); endsequence
   a_sync_quarter_rate: assert property (sync_rise |-> sync_next)
      else $error("sync clock period is not four clocks");
   a_pin_driven_out: assert property (io_update_out |-> io_update_oe)
      else $error("update pulse while pin not driven");
   a_pulse_with_strobe: assert property (io_update_out |-> update_strobe)
      else $error("pin pulse without transfer");
   a_external_update: assert property (io_update_in && !io_update_oe |-> ##[1:2] update_strobe)
      else $error("external update gave no transfer");
   a_read_answer: assert property (read_valid == $past(bus.read))
      else $error("read answer late or spurious");
   a_port_exclusive: assert property (cfg.parallel_port != cfg.serial_port)
      else $error("parallel and serial port both or neither");
   a_serial_needs_quad: assert property (cfg.serial_port |-> $past(operating_mode) == UCR2_MODE_QUAD)
      else $error("serial port outside quadrature mode");
   a_order_gated: assert property (cfg.lsb_first |-> cfg.serial_port && cfg.gpio_enable)
      else $error("bit order active without serial port");
endmodule
bind ucr2_control ucr2_control_chk chk (.clk(clk), .reset(reset), .bus(bus),
   .operating_mode(operating_mode), .io_update_in(io_update_in),
   .io_update_out(io_update_out), .io_update_oe(io_update_oe),
   .update_strobe(update_strobe), .sync_clk(sync_clk), .cfg(cfg), .read_valid(read_valid));

// *** ucr2_host.sv ***
// host model issuing one-cycle requests on the serial control port
`timescale 1ns/1ps
module ucr2_host
   import ucr2_pkg::*;
(
   input wire logic clk,
   input wire logic read_valid,
   input wire logic [31:0] read_data,
   output ucr2_bus_type bus
);
   initial bus = '0;
   task automatic access(input logic rd, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] q);
      int n;
      @(posedge clk);
      bus <= '{write: !rd, read: rd, addr: a, wdata: d};
      @(posedge clk);
      // released lines show the inverse, not a stale copy
      bus <= '{write: 1'b0, read: 1'b0, addr: ~a, wdata: ~d};
      q = '0;
      for (n = 0; rd && n < 4; n++) begin
         #1;
         if (read_valid === 1'b1) begin
            q = read_data;
            break;
         end
         @(posedge clk);
      end
   endtask
endmodule

// *** upconverter_control_reg_two_upper_bench.sv ***
// testbench for the upper half of the second control register
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_errors++; \
   $display("MISMATCH %0t got %h exp %h", $time, a, e); end end
module upconverter_control_reg_two_upper_bench;
   import ucr2_pkg::*;
   localparam logic [15:0] TICKS = 16'h0002;
   logic clk = 0, reset = 1, osk_enable = 0, io_update_in = 0;
   logic [1:0] operating_mode = UCR2_MODE_QUAD;
   logic [31:0] ftw_stored = 32'h1234_5678, ftw_live = 32'h89AB_CDEF, q;
   logic io_update_out, io_update_oe, update_strobe, sync_clk, read_valid;
   logic [31:0] read_data;
   ucr2_bus_type bus;
   ucr2_cfg_type cfg;
   int n_errors = 0, n_compared = 0, n;
   always #2 clk = ~clk;
   ucr2_host host (.clk(clk), .read_valid(read_valid), .read_data(read_data), .bus(bus));
   ucr2_control #(.UPDATE_TICKS(TICKS)) dut (.clk(clk), .reset(reset), .bus(bus),
      .operating_mode(operating_mode), .osk_enable(osk_enable), .ftw_stored(ftw_stored),
      .ftw_live(ftw_live), .io_update_in(io_update_in), .io_update_out(io_update_out),
      .io_update_oe(io_update_oe), .update_strobe(update_strobe), .sync_clk(sync_clk),
      .cfg(cfg), .read_data(read_data), .read_valid(read_valid));
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      host.access(1'b0, a, d, q);
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      host.access(1'b1, a, 32'h0000_0000, q);
      `CHK(q, e)
   endtask
   // external controller pulses the update pin for one clock
   task automatic upd();
      @(posedge clk) io_update_in <= 1'b1;
      @(posedge clk) io_update_in <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
   endtask
   task automatic conclude();
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // waits for the next internal pin pulse under a bound
   task automatic next_pulse(output int c);
      c = 0;
      do begin @(posedge clk); #1; c++; end while (io_update_out !== 1'b1 && c < 200);
   endtask
   initial begin
      #200000;
      n_errors++;
      conclude();
   end
   initial begin
      repeat (8) @(posedge clk);
      reset <= 1'b0;
      #1;
      `CHK(cfg.parallel_port, 1'b1)
      rd(UCR2_CTL2_ADDR, UCR2_CTL2_RESET);
      wr(UCR2_CTL2_ADDR, 32'hFFFF_FFFF);
      rd(UCR2_CTL2_ADDR, 32'hE1C1_C000);
      wr(8'h02, 32'h0000_0000);
      rd(UCR2_CTL2_ADDR, 32'hE1C1_C000);
      rd(8'h02, 32'h0000_0000);
      wr(UCR2_CTL2_ADDR, 32'h0040_0000);
      upd();
      wr(UCR2_CTL2_ADDR, 32'hE040_0000);
      `CHK(cfg.serial_port, 1'b0)
      upd();
      `CHK(cfg, 7'b0111100)
      @(posedge clk) operating_mode <= UCR2_MODE_TONE;
      repeat (2) @(posedge clk);
      #1;
      `CHK(cfg.parallel_port, 1'b1)
      wr(UCR2_CTL2_ADDR, 32'h0140_0000);
      upd();
      `CHK(cfg.profile_asf, 1'b1)
      @(posedge clk) osk_enable <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      `CHK(cfg.profile_asf, 1'b0)
      @(posedge clk) osk_enable <= 1'b0;
      wr(UCR2_CTL2_ADDR, 32'h0040_0000);
      upd();
      `CHK(cfg.asf_bypass, 1'b1)
      rd(UCR2_FTW_ADDR, 32'h1234_5678);
      wr(UCR2_CTL2_ADDR, 32'h0041_0000);
      upd();
      rd(UCR2_FTW_ADDR, 32'h89AB_CDEF);
      wr(UCR2_CTL2_ADDR, 32'h0000_0000);
      upd();
      for (n = 0; n < 8; n++) begin
         @(posedge clk);
         #1;
         `CHK(sync_clk, 1'b0)
      end
      for (int r = 0; r < 4; r++) begin
         wr(UCR2_CTL2_ADDR, 32'h0080_0000 | (32'(r) << 14));
         repeat (2) @(posedge clk);
         #1;
         `CHK(io_update_oe, 1'b1)
         repeat (2) next_pulse(n);
         next_pulse(n);
         `CHK(n, int'(TICKS) << r)
      end
      conclude();
   end
endmodule
